// ### logic/sds_pkg.sv
// shared constants and types for the low-power sdram device core
// assumes a single clock; the controller drives every pin on that clock
package sds_pkg;
	localparam int BANK_W = 2;
	localparam int ROW_W  = 13;
	localparam int COL_W  = 10;
	localparam int DQ_W   = 16;
	localparam int LANES  = 2;

	// command pins sampled together on the rising edge
	typedef struct packed {
		logic                  cke;
		logic                  cs_n;
		logic                  ras_n;
		logic                  cas_n;
		logic                  we_n;
		logic [BANK_W-1:0]     bank_pick;
		logic [ROW_W-1:0]      shared_addr_lines;
		logic [LANES-1:0]      dqm;
	} sds_pins_t;

	// {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_REF  = 3'h1;
	localparam logic [2:0] CMD_PRE  = 3'h2;
	localparam logic [2:0] CMD_ACT  = 3'h3;
	localparam logic [2:0] CMD_WR   = 3'h4;
	localparam logic [2:0] CMD_RD   = 3'h5;
	localparam logic [2:0] CMD_STOP = 3'h6;

	// mode field positions on the address lines
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WS_BIT = 9;
	localparam int AP_BIT      = 10;
	localparam logic [2:0] CL_TWO    = 3'h2;
	localparam logic [2:0] CL_THREE  = 3'h3;
	localparam logic [2:0] BL_FULL   = 3'h7;
	localparam logic [ROW_W-1:0] MODE_RST = 13'h0020;
	localparam logic [ROW_W-1:0] EXT_RST  = 13'h0000;

	// apb register map, byte addresses
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MODE   = 8'h04;
	localparam logic [7:0] REG_EXT    = 8'h08;
	localparam logic [7:0] REG_REFCNT = 8'h0C;
	localparam logic [7:0] REG_CTRL   = 8'h10;
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_MSK_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sds_apb_req_t;
endpackage : sds_pkg

// ### logic/sds_core.sv
// low-power sdram device core: command decode, banks, bursts, masks
// assumes pins are driven on clk_sys by the controller; apb on same clock
//
// Local design decisions: the APB slave port and the register offsets.
module sds_core #(
	parameter int ROW_W = sds_pkg::ROW_W,
	parameter int COL_W = sds_pkg::COL_W
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	input  wire sds_pkg::sds_pins_t       pins,
	input  wire logic [sds_pkg::DQ_W-1:0] data_pins_in,
	output logic      [sds_pkg::DQ_W-1:0] data_pins_out,
	output logic      [sds_pkg::DQ_W-1:0] data_pins_oe,
	input  wire sds_pkg::sds_apb_req_t    apb,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr
);
	localparam int BANKS = 1 << sds_pkg::BANK_W;
	localparam int AW    = sds_pkg::BANK_W + ROW_W + COL_W;
	localparam int DEPTH = 1 << AW;
	localparam int LW    = sds_pkg::DQ_W / sds_pkg::LANES;

	logic [sds_pkg::DQ_W-1:0] mem_r [0:DEPTH-1];
	logic [ROW_W-1:0]         row_r [0:BANKS-1];
	logic [BANKS-1:0]         open_r;
	logic [sds_pkg::ROW_W-1:0] mode_r;
	logic [sds_pkg::ROW_W-1:0] ext_r;
	logic                     cke_prev_r;
	logic                     self_ref_r;
	logic                     deep_pd_r;
	logic                     pwr_down_r;

	// burst state
	logic                      bst_act_r;
	logic                      bst_wr_r;
	logic                      bst_ap_r;
	logic [sds_pkg::BANK_W-1:0] bst_bank_r;
	logic [COL_W-1:0]          bst_col_r;
	logic [COL_W:0]            bst_idx_r;

	// read pipe and output stage
	logic [1:0]               pvld_r;
	logic [sds_pkg::DQ_W-1:0] pdat_r [0:1];
	logic [sds_pkg::LANES-1:0] dqm_d_r;
	logic [sds_pkg::DQ_W-1:0] dout_r;
	logic [sds_pkg::DQ_W-1:0] doe_r;

	logic [15:0] refcnt_r;
	logic [1:0]  ctrl_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	// command decode
	logic                      active;
	logic                      cmd_ok;
	logic [2:0]                cmd;
	logic [sds_pkg::BANK_W-1:0] ba;
	logic [sds_pkg::ROW_W-1:0] ad;
	logic                      is_mode;
	logic                      is_ref;
	logic                      is_pre;
	logic                      is_act;
	logic                      is_col;
	logic                      is_stop;

	assign active  = cke_prev_r;
	assign cmd_ok  = active && !pins.cs_n;
	assign cmd     = {pins.ras_n, pins.cas_n, pins.we_n};
	assign ba      = pins.bank_pick;
	assign ad      = pins.shared_addr_lines;
	assign is_mode = cmd_ok && pins.cke && cmd == sds_pkg::CMD_MODE;
	assign is_ref  = cmd_ok && cmd == sds_pkg::CMD_REF;
	assign is_pre  = cmd_ok && pins.cke && cmd == sds_pkg::CMD_PRE;
	assign is_act  = cmd_ok && pins.cke && cmd == sds_pkg::CMD_ACT;
	assign is_col  = cmd_ok && pins.cke && (cmd == sds_pkg::CMD_RD || cmd == sds_pkg::CMD_WR);
	assign is_stop = cmd_ok && pins.cke && cmd == sds_pkg::CMD_STOP;

	// mode fields
	logic [2:0]       cl;
	logic [2:0]       bl_code;
	logic             bt;
	logic [COL_W:0]   blen;
	logic [COL_W-1:0] bmask;

	assign cl      = mode_r[sds_pkg::MODE_CL_LSB +: 3];
	assign bl_code = mode_r[sds_pkg::MODE_BL_LSB +: 3];
	assign bt      = mode_r[sds_pkg::MODE_BT_BIT];

	always_comb begin
		unique case (bl_code)
			3'h0:             blen = (COL_W+1)'(1);
			3'h1:             blen = (COL_W+1)'(2);
			3'h2:             blen = (COL_W+1)'(4);
			3'h3:             blen = (COL_W+1)'(8);
			sds_pkg::BL_FULL: blen = (COL_W+1)'(1) << COL_W;
			default:          blen = (COL_W+1)'(1);
		endcase
		bmask = COL_W'(blen - (COL_W+1)'(1));
	end

	// current column access: a new column command interrupts any burst
	logic                       acc;
	logic                       acc_wr;
	logic                       acc_ap;
	logic [sds_pkg::BANK_W-1:0] acc_bank;
	logic [COL_W-1:0]           acc_base;
	logic [COL_W:0]             acc_idx;
	logic [COL_W:0]             acc_len;
	logic [COL_W-1:0]           acc_col;
	logic [COL_W-1:0]           step;
	logic [AW-1:0]              acc_addr;
	logic                       acc_last;

	always_comb begin
		acc      = active && (is_col || bst_act_r);
		acc_wr   = is_col ? !pins.we_n : bst_wr_r;
		acc_ap   = is_col ? ad[sds_pkg::AP_BIT] : bst_ap_r;
		acc_bank = is_col ? ba : bst_bank_r;
		acc_base = is_col ? ad[COL_W-1:0] : bst_col_r;
		acc_idx  = is_col ? '0 : bst_idx_r;
		acc_len  = (acc_wr && mode_r[sds_pkg::MODE_WS_BIT]) ? (COL_W+1)'(1) : blen;
		step     = bt ? (acc_base ^ acc_idx[COL_W-1:0])
			: COL_W'(acc_base + acc_idx[COL_W-1:0]);
		acc_col  = (acc_base & ~bmask) | (step & bmask);
		acc_addr = {acc_bank, row_r[acc_bank], acc_col};
		acc_last = (acc_idx + (COL_W+1)'(1)) >= acc_len;
	end

	// clock gate history, power states
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cke_prev_r <= 1'b0;
			self_ref_r <= 1'b0;
			deep_pd_r  <= 1'b0;
			pwr_down_r <= 1'b0;
		end else begin
			cke_prev_r <= pins.cke;
			if (active && !pins.cke) begin
				self_ref_r <= is_ref;
				deep_pd_r  <= is_stop || (cmd_ok && cmd == sds_pkg::CMD_STOP);
				pwr_down_r <= open_r == '0 && !bst_act_r;
			end else if (pins.cke) begin
				self_ref_r <= 1'b0;
				deep_pd_r  <= 1'b0;
				pwr_down_r <= 1'b0;
			end
		end
	end

	// mode and extended mode loads
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= sds_pkg::MODE_RST;
			ext_r  <= sds_pkg::EXT_RST;
		end else if (is_mode) begin
			if (ba[1]) begin
				ext_r <= ad;
			end else if (ad[sds_pkg::MODE_CL_LSB +: 3] == sds_pkg::CL_TWO
				|| ad[sds_pkg::MODE_CL_LSB +: 3] == sds_pkg::CL_THREE) begin
				mode_r <= ad;
			end
		end
	end

	// row open and close per bank
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			open_r <= '0;
		end else begin
			if (acc && acc_last && acc_ap) begin
				open_r[acc_bank] <= 1'b0;
			end
			if (is_pre) begin
				if (ad[sds_pkg::AP_BIT]) begin
					open_r <= '0;
				end else begin
					open_r[ba] <= 1'b0;
				end
			end
			if (is_act) begin
				open_r[ba] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (is_act) begin
			row_r[ba] <= ad[ROW_W-1:0];
		end
	end

	// burst progress
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bst_act_r  <= 1'b0;
			bst_wr_r   <= 1'b0;
			bst_ap_r   <= 1'b0;
			bst_bank_r <= '0;
			bst_col_r  <= '0;
			bst_idx_r  <= '0;
		end else if (active) begin
			if (acc) begin
				bst_act_r  <= !acc_last;
				bst_wr_r   <= acc_wr;
				bst_ap_r   <= acc_ap;
				bst_bank_r <= acc_bank;
				bst_col_r  <= acc_base;
				bst_idx_r  <= acc_idx + (COL_W+1)'(1);
			end
			if (is_stop || (is_pre && (ad[sds_pkg::AP_BIT] || ba == acc_bank))) begin
				bst_act_r <= 1'b0;
			end
		end
	end

	// write with zero mask latency
	always_ff @(posedge clk_sys) begin
		if (acc && acc_wr && !(is_stop && !is_col)) begin
			for (int l = 0; l < sds_pkg::LANES; l++) begin
				if (!pins.dqm[l]) begin
					mem_r[acc_addr][l*LW +: LW] <= data_pins_in[l*LW +: LW];
				end
			end
		end
	end

	// read pipe, frozen with the clock gate
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pvld_r <= '0;
		end else if (active) begin
			pvld_r[0] <= acc && !acc_wr && !(is_stop && !is_col);
			pvld_r[1] <= pvld_r[0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (active) begin
			pdat_r[0] <= mem_r[acc_addr];
			pdat_r[1] <= pdat_r[0];
		end
	end

	// output stage: latency selects the pipe tap, mask delayed one clock
	logic                      tap_vld;
	logic [sds_pkg::DQ_W-1:0]  tap_dat;

	always_comb begin
		tap_vld = (cl == sds_pkg::CL_THREE) ? pvld_r[1] : pvld_r[0];
		tap_dat = (cl == sds_pkg::CL_THREE) ? pdat_r[1] : pdat_r[0];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dqm_d_r <= '0;
			dout_r  <= '0;
			doe_r   <= '0;
		end else if (active) begin
			dqm_d_r <= pins.dqm;
			dout_r  <= tap_dat;
			for (int l = 0; l < sds_pkg::LANES; l++) begin
				doe_r[l*LW +: LW] <= {LW{tap_vld && !dqm_d_r[l]
					&& !ctrl_r[sds_pkg::CTRL_MSK_BIT]}};
			end
		end
	end

	assign data_pins_out = dout_r;
	assign data_pins_oe  = doe_r;

	// apb slave: zero wait, data registered in the setup cycle
	logic apb_setup;
	logic apb_wr;
	logic [31:0] rd_val;
	logic        rd_err;

	assign apb_setup = apb.psel && !apb.penable;
	assign apb_wr    = apb.psel && apb.penable && apb.pwrite;

	always_comb begin
		rd_err = 1'b0;
		unique case (apb.paddr)
			sds_pkg::REG_STATUS: rd_val = {24'h00_0000, deep_pd_r, self_ref_r,
				pwr_down_r, bst_act_r, open_r};
			sds_pkg::REG_MODE:   rd_val = 32'(mode_r);
			sds_pkg::REG_EXT:    rd_val = 32'(ext_r);
			sds_pkg::REG_REFCNT: rd_val = {16'h0000, refcnt_r};
			sds_pkg::REG_CTRL:   rd_val = {30'h0000_0000, ctrl_r};
			default: begin
				rd_val = 32'h0000_0000;
				rd_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (apb_setup) begin
			prdata_r  <= apb.pwrite ? 32'h0000_0000 : rd_val;
			pslverr_r <= rd_err;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r <= sds_pkg::CTRL_RST;
		end else if (apb_wr && apb.paddr == sds_pkg::REG_CTRL) begin
			ctrl_r <= apb.pwdata[1:0];
		end else begin
			ctrl_r[sds_pkg::CTRL_CLR_BIT] <= 1'b0;
		end
	end

	// refresh counter: a refresh in the clearing cycle still counts
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			refcnt_r <= 16'h0000;
		end else if (ctrl_r[sds_pkg::CTRL_CLR_BIT]) begin
			refcnt_r <= {15'h0000, is_ref && pins.cke};
		end else if (is_ref && pins.cke) begin
			refcnt_r <= refcnt_r + 16'h0001;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = apb.psel && apb.penable;
	assign pslverr = pslverr_r && apb.psel && apb.penable;
endmodule : sds_core

// ### test/sds_core_sva.sv
// checker for the sdram device core ports
// assumes one clock domain; bound to every sds_core instance
module sds_core_sva (
	input wire logic                     clk_sys,
	input wire logic                     rst,
	input wire sds_pkg::sds_pins_t       pins,
	input wire logic [sds_pkg::DQ_W-1:0] data_pins_in,
	input wire logic [sds_pkg::DQ_W-1:0] data_pins_out,
	input wire logic [sds_pkg::DQ_W-1:0] data_pins_oe,
	input wire sds_pkg::sds_apb_req_t    apb,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr
);
	logic cke_r;
	logic rd;
	always_ff @(posedge clk_sys) begin
		cke_r <= rst ? 1'b0 : pins.cke;
	end
	// a read the device must take
	assign rd = cke_r && pins.cke && !pins.cs_n
		&& {pins.ras_n, pins.cas_n, pins.we_n} == sds_pkg::CMD_RD;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_rd_out;
		rd && pins.dqm == 2'h0 ##1 pins.cke && pins.dqm == 2'h0 |-> ##[1:2] data_pins_oe == 16'hffff;
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("read beat not driven");
	property p_b2b;
		rd && pins.dqm == 2'h0 ##1 rd && pins.dqm == 2'h0 ##1 pins.cke && pins.dqm == 2'h0
			|-> ##[0:1] (data_pins_oe == 16'hffff) [*2];
	endproperty
	a_b2b: assert property (p_b2b) else $error("back to back reads lost a beat");
	property p_rise;
		$rose(data_pins_oe[8]) |-> $past(rd, 2) || $past(rd, 3) || $past(pins.dqm[1], 3);
	endproperty
	a_rise: assert property (p_rise) else $error("output driven without a read");
	property p_freeze;
		!pins.cke |=> ##1 $stable(data_pins_out) && $stable(data_pins_oe);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while gated");
	property p_mask;
		pins.cke && pins.dqm[0] |-> ##2 data_pins_oe[7:0] == 8'h00;
	endproperty
	a_mask: assert property (p_mask) else $error("masked lane still driven");
	property p_lanes;
		data_pins_oe[7:0] inside {8'h00, 8'hff} && data_pins_oe[15:8] inside {8'h00, 8'hff};
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane enable split");
	property p_apb_rdy;
		apb.psel && !apb.penable ##1 apb.psel && apb.penable |-> pready;
	endproperty
	a_apb_rdy: assert property (p_apb_rdy) else $error("access phase not ready");
	property p_apb_err;
		apb.psel && apb.penable && apb.paddr > 8'h13 |-> pslverr;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");
endmodule : sds_core_sva

bind sds_core sds_core_sva u_sva (.clk_sys(clk_sys), .rst(rst), .pins(pins), .data_pins_in(data_pins_in),
	.data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .apb(apb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

// ### test/sds_ctl_model.sv
// controller model driving the sdram command pins and write data
// assumes its tasks are called at a rising clock edge
module sds_ctl_model #(
	parameter int GRADE = 5
) (
	input  wire logic                clk_sys,
	output sds_pkg::sds_pins_t       pins,
	output logic [sds_pkg::DQ_W-1:0] data_pins_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T_CK = 10;
	localparam int RCD = ((GRADE == 5 ? 15 : GRADE == 6 ? 18 : 21) + T_CK - 1) / T_CK;
	localparam int RRD = ((GRADE == 5 ? 10 : 12) + T_CK - 1) / T_CK;
	localparam int RFC = (96 + T_CK - 1) / T_CK;
	initial begin
		pins = '0;
		pins.cs_n = 1'b1;
		data_pins_in = 16'h0000;
	end
	task automatic drive(input logic ck, input logic cs, input logic [2:0] op, input logic [1:0] ba,
		input logic [12:0] a, input logic [1:0] m, input logic [15:0] d);
		pins <= '{ck, cs, op[2], op[1], op[0], ba, a, m};
		data_pins_in <= d;
		@(posedge clk_sys);
	endtask : drive
	// released lines flip every cycle so stale values never look valid
	task automatic nop(input int n);
		repeat (n) drive(1'b1, 1'b1, 3'h7, ~pins.bank_pick, ~pins.shared_addr_lines, 2'h0, ~data_pins_in);
	endtask : nop
	task automatic beat(input logic [15:0] d);
		drive(1'b1, 1'b1, 3'h7, ~pins.bank_pick, ~pins.shared_addr_lines, 2'h0, d);
	endtask : beat
	task automatic sleep(input int n);
		repeat (n) drive(1'b0, 1'b1, 3'h7, ~pins.bank_pick, ~pins.shared_addr_lines, 2'h0, ~data_pins_in);
		nop(1);
	endtask : sleep
	task automatic cmd(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a, input logic [1:0] m,
		input logic [15:0] d);
		drive(1'b1, 1'b0, op, ba, a, m, d);
		case (op)
		sds_pkg::CMD_ACT: nop((RCD > RRD ? RCD : RRD) - 1);
		sds_pkg::CMD_PRE: nop(RCD - 1);
		sds_pkg::CMD_MODE: nop(1);
		sds_pkg::CMD_REF: nop(RFC - 1);
		default: ;
		endcase
	endtask : cmd
endmodule : sds_ctl_model

// ### test/sds_core_bench.sv
// self-checking bench for the sdram device core
// pins come from the controller model, registers over apb
module sds_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	sds_pkg::sds_pins_t    pins;
	logic [15:0]           din;
	logic [15:0]           dout;
	logic [15:0]           oe;
	sds_pkg::sds_apb_req_t apb = '0;
	logic [31:0]           prdata;
	logic [31:0]           rdat;
	logic                  pready;
	logic                  pslverr;
	logic                  rerr;
	int                    err_total = 0;
	int                    n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	sds_ctl_model m (.clk_sys(clk_sys), .pins(pins), .data_pins_in(din));
	sds_core #(.ROW_W(4), .COL_W(4)) dut (.clk_sys(clk_sys), .rst(rst), .pins(pins), .data_pins_in(din),
		.data_pins_out(dout), .data_pins_oe(oe), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb_go(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		apb <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clk_sys);
		apb.penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		apb <= '0;
		@(posedge clk_sys);
	endtask : apb_go
	task automatic rd_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb_go(1'b0, a, 32'h0000_0000);
		chk(what, rdat, exp);
	endtask : rd_reg
	task automatic t_regs();
		rd_reg("mode", sds_pkg::REG_MODE, 32'h0000_0020);
		apb_go(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped err", 32'(rerr), 32'h0000_0001);
	endtask : t_regs
	task automatic t_refresh();
		repeat (2) m.cmd(sds_pkg::CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0000);
		rd_reg("refcnt", sds_pkg::REG_REFCNT, 32'h0000_0002);
		apb_go(1'b1, sds_pkg::REG_CTRL, 32'h0000_0001);
		rd_reg("refcnt clr", sds_pkg::REG_REFCNT, 32'h0000_0000);
	endtask : t_refresh
	task automatic t_mask();
		m.cmd(sds_pkg::CMD_ACT, 2'h1, 13'h0003, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_ACT, 2'h2, 13'h0003, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_WR, 2'h1, 13'h0005, 2'h0, 16'h1234);
		m.cmd(sds_pkg::CMD_WR, 2'h1, 13'h0005, 2'h1, 16'habcd);
		m.cmd(sds_pkg::CMD_WR, 2'h2, 13'h0005, 2'h0, 16'h5a5a);
		m.sleep(3);
		m.cmd(sds_pkg::CMD_RD, 2'h1, 13'h0005, 2'h0, 16'h0000);
		m.nop(2);
		chk("bank1 word", 32'(dout), 32'h0000_ab34);
		m.cmd(sds_pkg::CMD_RD, 2'h2, 13'h0005, 2'h2, 16'h0000);
		m.nop(2);
		chk("masked oe", 32'(oe), 32'h0000_00ff);
		chk("bank2 low", 32'(dout[7:0]), 32'h0000_005a);
		m.drive(1'b1, 1'b1, sds_pkg::CMD_RD, 2'h1, 13'h0005, 2'h0, 16'h0000);
		m.nop(2);
		chk("deselected oe", 32'(oe), 32'h0000_0000);
		// forced high-z: dqm only masks the cycle after, so the beat itself is unmasked
		apb_go(1'b1, sds_pkg::REG_CTRL, 32'h0000_0002);
		m.cmd(sds_pkg::CMD_RD, 2'h1, 13'h0005, 2'h0, 16'h0000);
		m.drive(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000, 2'h3, 16'h0000);
		m.nop(1);
		chk("forced hi-z", 32'(oe), 32'h0000_0000);
		rd_reg("ctrl", sds_pkg::REG_CTRL, 32'h0000_0002);
		apb_go(1'b1, sds_pkg::REG_CTRL, 32'h0000_0000);
		rd_reg("status open", sds_pkg::REG_STATUS, 32'h0000_0006);
	endtask : t_mask
	task automatic t_burst();
		m.cmd(sds_pkg::CMD_PRE, 2'h0, 13'h0400, 2'h0, 16'h0000);
		// gate low with all banks idle: power down, held while registers are read
		m.drive(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000, 2'h0, 16'h0000);
		rd_reg("power down", sds_pkg::REG_STATUS, 32'h0000_0020);
		m.nop(1);
		m.cmd(sds_pkg::CMD_MODE, 2'h0, 13'h003a, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_MODE, 2'h0, 13'h0012, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_MODE, 2'h2, 13'h0005, 2'h0, 16'h0000);
		rd_reg("mode", sds_pkg::REG_MODE, 32'h0000_003a);
		rd_reg("ext", sds_pkg::REG_EXT, 32'h0000_0005);
		m.cmd(sds_pkg::CMD_ACT, 2'h0, 13'h0003, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_WR, 2'h0, 13'h0009, 2'h0, 16'hd000);
		for (int i = 1; i < 4; i++) m.beat(16'hd000 + 16'(i));
		m.cmd(sds_pkg::CMD_RD, 2'h0, 13'h0008, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_RD, 2'h0, 13'h000a, 2'h0, 16'h0000);
		m.nop(2);
		chk("cl3 first", 32'(dout), 32'h0000_d001);
		m.nop(1);
		chk("cut burst", 32'(dout), 32'h0000_d003);
		m.nop(1);
		chk("wrap beat", 32'(dout), 32'h0000_d002);
		m.cmd(sds_pkg::CMD_RD, 2'h0, 13'h0008, 2'h0, 16'h0000);
		m.cmd(sds_pkg::CMD_STOP, 2'h0, 13'h0000, 2'h0, 16'h0000);
		m.nop(2);
		chk("stop first", 32'(dout), 32'h0000_d001);
		m.nop(1);
		chk("stopped oe", 32'(oe), 32'h0000_0000);
		m.cmd(sds_pkg::CMD_RD, 2'h0, 13'h0008, 2'h0, 16'h0000);
		m.nop(4);
		m.drive(1'b1, 1'b0, sds_pkg::CMD_PRE, 2'h0, 13'h0000, 2'h0, 16'h0000);
		m.nop(1);
		chk("last beat", 32'(dout), 32'h0000_d002);
	endtask : t_burst
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		m.nop(2);
		t_regs();
		t_refresh();
		t_mask();
		t_burst();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		tally_and_finish();
	end
endmodule : sds_core_bench
